// File: inc/sarcc_pkg.sv
// Shared types and constants for the SAR conversion control block
package sarcc_pkg;
  // ==========================================
  // Timing
  localparam int CLK_NS = 50;
  localparam int T_ACQ_NS = 1000;
  localparam int T_APER_NS = 50;
  localparam int T_SAMPLE_NS = 4000;
  localparam int ACQ_CYC = (T_ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int APER_CYC = (T_APER_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CYC = T_SAMPLE_NS / CLK_NS;
  localparam int STEP_DIV = 3;
  localparam int RES_BITS = 16;
  localparam int CFG_BITS = 3;
  // ==========================================
  // Codes
  localparam logic [15:0] CODE_MSB = 16'h8000;
  localparam logic [15:0] CODE_ONES = 16'hFFFF;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_LSB = 16'h0001;
  localparam logic [15:0] TWOS_MAX = 16'h7FFF;
  localparam logic [15:0] TWOS_MIN = 16'h8000;
  // ==========================================
  // Configuration word: serial order ten, bipolar, coding
  typedef struct packed {
    logic ten;
    logic bipolar;
    logic coding_select; // 1 = straight binary, 0 = twos complement
  } sarcc_cfg_t;
  localparam sarcc_cfg_t CFG_RST = 3'h1;
  // Pins that cross into the clock domain
  typedef struct packed {
    logic conversion_start_n;
    logic coding_select;
    logic interface_select;
    logic config_source_select;
    logic ten;
    logic bipolar;
    logic cfg_sclk;
    logic cfg_sdin;
    logic cfg_cs_n;
    logic comp_above;
    logic over_pos;
    logic over_neg;
  } sarcc_pins_t;
  localparam sarcc_pins_t PINS_RST = 12'h808;
  typedef enum logic [3:0] {
    ST_ACQ = 4'h1,
    ST_APER = 4'h2,
    ST_CONV = 4'h4,
    ST_CODE = 4'h8
  } sarcc_state_t;
endpackage

// File: core/sarcc_top.sv
// SAR conversion control: sequencing, bit decisions and output coding
`timescale 1ns/1ps
`default_nettype none
module sarcc_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire sarcc_pkg::sarcc_pins_t i_pins,
  output logic o_busy,
  output logic o_pos_sample_switch,
  output logic o_neg_sample_switch,
  output logic [15:0] o_dac_code,
  output sarcc_pkg::sarcc_cfg_t o_cfg_applied,
  output logic [15:0] o_result_code,
  output logic o_result_valid
);
  import sarcc_pkg::*;

  // ==========================================
  // Pin synchronisers
  sarcc_pins_t sync1_reg;
  sarcc_pins_t pins_reg;
  sarcc_pins_t pins_d_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= PINS_RST;
      pins_reg <= PINS_RST;
      pins_d_reg <= PINS_RST;
    end
    else
    begin
      sync1_reg <= i_pins;
      pins_reg <= sync1_reg;
      pins_d_reg <= pins_reg;
    end
  end

  logic start_fall;
  logic sclk_rise;
  logic cs_rise;
  assign start_fall = pins_d_reg.conversion_start_n
    && !pins_reg.conversion_start_n;
  assign sclk_rise = pins_reg.cfg_sclk && !pins_d_reg.cfg_sclk;
  assign cs_rise = pins_reg.cfg_cs_n && !pins_d_reg.cfg_cs_n;

  // ==========================================
  // Write-only serial configuration register
  logic [CFG_BITS-1:0] shift_reg;
  logic [2:0] shift_cnt_reg;
  sarcc_cfg_t cfg_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      shift_reg <= '0;
      shift_cnt_reg <= '0;
      cfg_reg <= CFG_RST;
    end
    else if (pins_reg.cfg_cs_n)
    begin
      // Short frames are dropped, not half applied
      if (cs_rise && shift_cnt_reg == 3'(CFG_BITS))
        cfg_reg <= shift_reg;
      shift_cnt_reg <= '0;
    end
    else if (sclk_rise)
    begin
      shift_reg <= {shift_reg[CFG_BITS-2:0], pins_reg.cfg_sdin};
      if (shift_cnt_reg != 3'(CFG_BITS))
        shift_cnt_reg <= shift_cnt_reg + 3'h1;
    end
  end

  // ==========================================
  // Configuration source selection
  logic sw_mode;
  sarcc_cfg_t cfg_sel;
  assign sw_mode = pins_reg.interface_select
    && !pins_reg.config_source_select;
  always_comb
  begin
    if (sw_mode)
      cfg_sel = cfg_reg;
    else
      cfg_sel = '{ten: pins_reg.ten, bipolar: pins_reg.bipolar,
        coding_select: pins_reg.coding_select};
  end

  // ==========================================
  // Sequencer
  sarcc_state_t state_reg;
  logic [7:0] cnt_reg;
  logic [1:0] step_div_reg;
  logic step_en;
  logic [15:0] trial_reg;
  logic [15:0] mask_reg;
  logic acq_done;
  logic start_acc;
  assign acq_done = cnt_reg >= 8'(ACQ_CYC);
  assign start_acc = (state_reg == ST_ACQ) && acq_done
    && start_fall;
  assign step_en = step_div_reg == 2'(STEP_DIV - 1);

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= ST_ACQ;
    else
    begin
      unique case (state_reg)
        ST_ACQ:
          if (start_acc)
            state_reg <= ST_APER;
        ST_APER:
          if (cnt_reg >= 8'(APER_CYC - 1))
            state_reg <= ST_CONV;
        ST_CONV:
          if (step_en && mask_reg == CODE_LSB)
            state_reg <= ST_CODE;
        ST_CODE:
          state_reg <= ST_ACQ;
      endcase
    end
  end

  // Shared phase counter, cleared on every state change except the one into ST_CODE
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_reg <= '0;
    else if (start_acc || state_reg == ST_CODE
      || (state_reg == ST_APER && cnt_reg >= 8'(APER_CYC - 1)))
      cnt_reg <= '0;
    else if (cnt_reg != 8'hFF)
      cnt_reg <= cnt_reg + 8'h01;
  end

  // Bit step enable; three cycles cover DAC settle plus sync delay
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      step_div_reg <= '0;
    else if (state_reg != ST_CONV || step_en)
      step_div_reg <= '0;
    else
      step_div_reg <= step_div_reg + 2'h1;
  end

  // ==========================================
  // Successive approximation
  logic [15:0] trial_next;
  always_comb
  begin
    // Keep the bit when input is at or above the trial level
    trial_next = (pins_reg.comp_above ? trial_reg
      : (trial_reg & ~mask_reg)) | (mask_reg >> 1);
  end

  // DAC loads with the trial, so the comparator has the whole step
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      trial_reg <= CODE_MSB;
      mask_reg <= CODE_MSB;
      o_dac_code <= CODE_MSB;
    end
    else if (state_reg == ST_APER)
    begin
      trial_reg <= CODE_MSB;
      mask_reg <= CODE_MSB;
      o_dac_code <= CODE_MSB;
    end
    else if (state_reg == ST_CONV && step_en)
    begin
      trial_reg <= trial_next;
      mask_reg <= mask_reg >> 1;
      o_dac_code <= trial_next;
    end
  end

  // ==========================================
  // Configuration tracked for the first ACQ_CYC cycles of acquisition, then frozen
  // Tracking, not a single sample, keeps sync reset values out
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cfg_applied <= CFG_RST;
    else if (state_reg == ST_ACQ && !acq_done)
      o_cfg_applied <= cfg_sel;
  end

  // ==========================================
  // Output coding with saturation
  logic [15:0] bin_code;
  always_comb
  begin
    if (pins_reg.over_pos)
      bin_code = CODE_ONES;
    else if (pins_reg.over_neg)
      bin_code = CODE_ZERO;
    else
      bin_code = trial_reg;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_result_code <= CODE_ZERO;
      o_result_valid <= 1'b0;
    end
    else
    begin
      o_result_valid <= state_reg == ST_CODE;
      if (state_reg == ST_CODE)
        o_result_code <= o_cfg_applied.coding_select ? bin_code
          : bin_code ^ CODE_MSB;
    end
  end

  // ==========================================
  // Busy and sample switches
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_busy <= 1'b0;
    else if (start_acc)
      o_busy <= 1'b1;
    else if (state_reg == ST_CODE)
      o_busy <= 1'b0;
  end

  assign o_pos_sample_switch = state_reg == ST_ACQ
    || state_reg == ST_APER;
  assign o_neg_sample_switch = o_pos_sample_switch;

  // ==========================================
  // Checks
  localparam int BUSY_MAX = SAMPLE_CYC - ACQ_CYC;
  logic [7:0] busy_cnt_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_cnt_reg <= '0;
    else if (!o_busy)
      busy_cnt_reg <= '0;
    else if (busy_cnt_reg != 8'hFF)
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_start_needs_acq: assert property (
    $rose(o_busy) |-> $past(acq_done) && $past(start_fall))
    else $error("conversion began before acquisition ended");
  a_msb_first: assert property (
    $rose(state_reg == ST_CONV) |-> trial_reg == CODE_MSB)
    else $error("first trial is not the MSB");
  a_busy_falls_coded: assert property (
    $fell(o_busy) |-> o_result_valid)
    else $error("busy fell without a new result");
  a_twos_mapping: assert property (
    o_result_valid && !o_cfg_applied.coding_select
    |-> o_result_code == ($past(bin_code) ^ CODE_MSB))
    else $error("twos complement code wrong");
  a_sat_pos: assert property (
    state_reg == ST_CODE && pins_reg.over_pos
    |=> o_result_code == (o_cfg_applied.coding_select
    ? CODE_ONES : TWOS_MAX))
    else $error("positive overrange did not saturate");
  a_sat_neg: assert property (
    state_reg == ST_CODE && pins_reg.over_neg && !pins_reg.over_pos
    |=> o_result_code == (o_cfg_applied.coding_select
    ? CODE_ZERO : TWOS_MIN))
    else $error("negative overrange did not saturate");
  a_cfg_apply: assert property (
    state_reg == ST_ACQ && !acq_done
    |=> o_cfg_applied == $past(cfg_sel))
    else $error("configuration not taken at acquisition");
  a_sw_ignores_pins: assert property (
    sw_mode |-> cfg_sel == cfg_reg)
    else $error("pins steered configuration in software mode");
  a_aperture_hold: assert property (
    start_acc |=> o_pos_sample_switch ##1 !o_pos_sample_switch)
    else $error("input not held after aperture delay");
  a_busy_rises: assert property (
    start_acc |=> o_busy [*3])
    else $error("busy not raised on conversion start");
  a_busy_bound: assert property (
    busy_cnt_reg <= 8'(BUSY_MAX))
    else $error("conversion too long for sample rate");
  a_one_result: assert property (
    $rose(o_busy) |-> ##[1:60] o_result_valid)
    else $error("result did not follow its conversion");

  c_conversion: cover property ($fell(o_busy));
  c_twos: cover property (o_result_valid
    && !o_cfg_applied.coding_select);
  c_sw_write: cover property (cs_rise
    && shift_cnt_reg == 3'(CFG_BITS));
  c_overrange: cover property (state_reg == ST_CODE
    && pins_reg.over_pos);
endmodule // sarcc_top
`default_nettype wire

// File: testbench/sarcc_front_model.sv
// Comparator model standing in for the analog front of the converter
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Comparator
module sarcc_front_model (
  input wire logic [15:0] i_dac_code,
  input wire logic [15:0] i_level,
  output logic o_comp_above
);
  // Ideal and instant, so the search must land on the level itself
  assign o_comp_above = (i_level >= i_dac_code);
endmodule // sarcc_front_model
`default_nettype wire

// File: testbench/sar_conversion_control_tb_top.sv
// Self-checking bench for the SAR conversion control block
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_control_tb_top;
  import sarcc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_n = 1'b1;
  logic cod = 1'b1;
  logic ifs = 1'b0;
  logic css = 1'b1;
  logic ten = 1'b0;
  logic bip = 1'b0;
  logic sclk = 1'b0;
  logic sdin = 1'b0;
  logic cs_n = 1'b1;
  logic ovp = 1'b0;
  logic ovn = 1'b0;
  logic comp;
  logic pc = 1'b1;
  logic [15:0] level = 16'h0000;
  logic [15:0] lv [6] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF,
    16'h0001, 16'hA5C3};
  sarcc_pins_t pins;
  logic busy, sw_p, sw_n, valid;
  logic [15:0] dac, result;
  sarcc_cfg_t cfg_applied;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  assign pins = {start_n, cod, ifs, css, ten, bip, sclk, sdin, cs_n, comp,
    ovp, ovn};

  sarcc_top sarcc_top_inst (
    .i_sys_clk(clk),
    .i_rst_n(rst_n),
    .i_pins(pins),
    .o_busy(busy),
    .o_pos_sample_switch(sw_p),
    .o_neg_sample_switch(sw_n),
    .o_dac_code(dac),
    .o_cfg_applied(cfg_applied),
    .o_result_code(result),
    .o_result_valid(valid)
  );

  sarcc_front_model sarcc_front_model_inst (
    .i_dac_code(dac),
    .i_level(level),
    .o_comp_above(comp)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  // ==========================================
  // Report and checks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_code(input logic [15:0] b,
    input logic bin);
    return bin ? b : (b ^ CODE_MSB);
  endfunction

  // Whole run is near 2500 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  // ==========================================
  // Access tasks
  task automatic convert(input logic [15:0] lvl, input logic op,
    input logic on, input logic [15:0] exp);
    int n;
    n = 0;
    level = lvl;
    ovp = op;
    ovn = on;
    start_n = 1'b0;
    while (busy !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(busy), 16'h0001);
    start_n = 1'b1;
    repeat (8) @(negedge clk);
    n += 8;
    chk(16'({sw_p, sw_n, busy}), 16'h0001);
    while (valid !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk(result, exp);
    chk(16'(busy), 16'h0000);
    chk(16'(n + 20 <= 80), 16'h0001);
    // Too early: must be dropped, not queued
    start_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(busy), 16'h0000);
    start_n = 1'b1;
    repeat (22) @(negedge clk);
  endtask

  // Pin levels held 3 clocks since the port is oversampled
  task automatic cfg_write(input logic [2:0] w);
    cs_n = 1'b0;
    for (int i = 2; i >= 0; i--)
    begin
      sdin = w[i];
      repeat (3) @(negedge clk);
      sclk = 1'b1;
      repeat (3) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge clk);
    cs_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  // ==========================================
  // Sequence
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk(16'({busy, valid, sw_p, sw_n}), 16'h0003);
    chk(16'(cfg_applied), 16'(CFG_RST));
    chk(result, CODE_ZERO);
    chk(dac, CODE_MSB);
    repeat (25) @(negedge clk);
    for (int k = 0; k < 2; k++)
    begin
      cod = (k == 1);
      // New coding only lands with the next acquisition
      convert(16'h8000, 1'b0, 1'b0, exp_code(16'h8000, ~cod));
      foreach (lv[j]) convert(lv[j], 1'b0, 1'b0, exp_code(lv[j], cod));
      convert(16'h1234, 1'b1, 1'b0, exp_code(CODE_ONES, cod));
      convert(16'h1234, 1'b0, 1'b1, exp_code(CODE_ZERO, cod));
      convert(16'h1234, 1'b1, 1'b1, exp_code(CODE_ONES, cod));
    end
    ifs = 1'b1;
    css = 1'b0;
    for (int w = 0; w < 8; w++)
    begin
      cfg_write(3'(w));
      // Pins set against the register to show they are ignored
      cod = ~w[0];
      bip = ~w[1];
      ten = ~w[2];
      convert(16'hC000, 1'b0, 1'b0, exp_code(16'hC000, pc));
      chk(16'(cfg_applied), 16'(w));
      pc = w[0];
    end
    convert(16'h3C5A, 1'b0, 1'b0, exp_code(16'h3C5A, pc));
    stop_test();
  end
endmodule // sar_conversion_control_tb_top
`default_nettype wire
